// File: logic/dual_fifo_status_flags.sv
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`include "dual_fifo_consts.svh"
`default_nettype none
// Functional notes
// - fall-through mode: ready flags; standard mode: full and empty flags
// - full flag high means a free slot; low ignores writes
// - full flag timed by writer clock; write pointer steps per accepted word
// - full comparator resolves full, full minus one, full minus two
// - full flag rises on second writer edge after the freeing read
// - writer edge counts only after skew interval from the read
// - almost-empty timed by reader clock; comparator resolves X, X+1, X+2
// - almost-empty low at count up to X, high from X+1
// - almost-empty rises on second reader edge after reaching X+1
// - reader edge counts only after second skew interval from the write
// - offsets preset at reset, written from wide side, or shifted serially
// - first queue: low offset for tx side, high offset for wide side
// - second queue: low offset for wide side, high offset for rx side
// - almost-full low at count capacity minus Y or more
// - empty flags low at zero words; full low only at capacity
// - output register word never counts as stored
// - fall-through moves first word out unrequested, freeing its slot
// - slot of a word shifted to output is free at once
// - with empty flag low, reads are ignored
module dual_fifo_status_flags
  import dual_fifo_pkg::*;
(
  // system
  input wire logic core_clk,
  input wire logic arst_n,
  // port clock and enable pins
  input wire logic wide_port_clock,
  input wire logic tx_port_clock,
  input wire logic rx_port_clock,
  input wire logic wide_wr_en,
  input wire logic wide_rd_en,
  input wire logic tx_rd_en,
  input wire logic rx_wr_en,
  // flags, active low where empty or full
  output logic wide_port_empty_or_ready,
  output logic tx_port_empty_or_ready,
  output logic wide_port_almost_empty,
  output logic tx_port_almost_empty,
  output logic wide_port_almost_full,
  output logic rx_port_almost_full,
  output logic wide_port_full_or_input_ready,
  output logic rx_port_full_or_input_ready,
  // avalon-mm slave
  input wire avalon_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  function automatic logic [10:0] bin2gray(input logic [10:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [10:0] gray2bin(input logic [10:0] g);
    logic [10:0] b;
    b = g;
    for (int i = 9; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  function automatic cmp_level_t dist_level(input logic [10:0] d);
    if (d == 11'h000) return LVL_AT;
    if (d == 11'h001) return LVL_NEAR1;
    if (d == 11'h002) return LVL_NEAR2;
    return LVL_CLEAR;
  endfunction : dist_level

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i * 8 +: 8] = n[i * 8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic block_state_t init_state();
    block_state_t s;
    s = '0;
    s.bus.wait_rq = 1'b1;
    s.bus.depth_sel = `DEPTH_PRESET;
    for (int q = 0; q < 2; q++) begin
      s.q[q].almost_full_n = 1'b1;
      s.q[q].full_n = 1'b1;
      s.q[q].low_off = `OFF_PRESET;
      s.q[q].high_off = `OFF_PRESET;
    end
    return s;
  endfunction : init_state

  localparam block_state_t ST_RST = init_state();

  block_state_t st_reg;
  block_state_t st_next;
  logic [6:0] pin_in;
  logic [2:0] tick;
  logic [1:0] wtick;
  logic [1:0] rtick;
  logic [1:0] wen;
  logic [1:0] ren;
  logic [1:0] wacc;
  logic [10:0] cap_w;
  logic [10:0] rcnt_obs [2];
  logic [10:0] wcnt_obs [2];

  // pin order: three clocks, then enables
  assign pin_in = {rx_wr_en, tx_rd_en, wide_rd_en, wide_wr_en,
                   rx_port_clock, tx_port_clock, wide_port_clock};
  // rising edge once second and third stages agree high
  assign tick = st_reg.pins.s1[2:0] & st_reg.pins.s2[2:0] & ~st_reg.pins.lvl[2:0];
  // queue 0 written by wide side, read by tx; queue 1 written by rx, read by wide
  assign wtick = {tick[2], tick[0]};
  assign rtick = {tick[0], tick[1]};
  assign wen = {st_reg.pins.lvl[6], st_reg.pins.lvl[3]};
  assign ren = {st_reg.pins.lvl[4], st_reg.pins.lvl[5]};
  // depth select: 256, 512, or 1024 words
  assign cap_w = (st_reg.bus.depth_sel >= 2'h2) ? 11'h400 :
                 (st_reg.bus.depth_sel == 2'h1) ? 11'h200 : 11'h100;

  // write acceptance and observed fill per queue
  for (genvar g = 0; g < 2; g++) begin : g_obs
    assign wacc[g] = wtick[g] & wen[g] & st_reg.q[g].full_n;
    assign rcnt_obs[g] = gray2bin(st_reg.q[g].wview_b) - st_reg.q[g].rptr;
    assign wcnt_obs[g] = st_reg.q[g].wptr - gray2bin(st_reg.q[g].rview_b);
  end

  // next state of pins, queues and bus
  always_comb begin
    logic [10:0] wcnt;
    logic [10:0] rcnt;
    logic [31:0] wd;
    logic [39:0] chain;
    logic shift;
    cmp_level_t lvl;
    wcnt = '0;
    rcnt = '0;
    wd = '0;
    chain = '0;
    shift = 1'b0;
    lvl = LVL_CLEAR;
    st_next = st_reg;
    // three-stage pin sampling; level accepted when stages two and three agree
    st_next.pins.s0 = pin_in;
    st_next.pins.s1 = st_reg.pins.s0;
    st_next.pins.s2 = st_reg.pins.s1;
    st_next.pins.lvl = (~(st_reg.pins.s1 ^ st_reg.pins.s2) & st_reg.pins.s2) |
                       ((st_reg.pins.s1 ^ st_reg.pins.s2) & st_reg.pins.lvl);
    for (int q = 0; q < 2; q++) begin
      // writer side: pointer step, read pointer view, full and almost-full
      if (wtick[q]) begin
        st_next.q[q].wptr = st_reg.q[q].wptr + {10'h000, wacc[q]};
        st_next.q[q].rview_a = bin2gray(st_reg.q[q].rptr);
        st_next.q[q].rview_b = st_reg.q[q].rview_a;
        wcnt = st_next.q[q].wptr - gray2bin(st_reg.q[q].rview_a);
        lvl = dist_level(cap_w - wcnt);
        st_next.q[q].full_n = (lvl != LVL_AT);
        st_next.q[q].almost_full_n = wcnt < (cap_w - {1'b0, st_reg.q[q].high_off});
      end
      // reader side: write pointer view, output register, empty and almost-empty
      if (rtick[q]) begin
        st_next.q[q].wview_a = bin2gray(st_reg.q[q].wptr);
        st_next.q[q].wview_b = st_reg.q[q].wview_a;
        rcnt = gray2bin(st_reg.q[q].wview_a) - st_reg.q[q].rptr;
        if (st_reg.bus.fall_through_mode) begin
          // first word falls through unrequested, later ones on a read
          shift = (rcnt != 11'h000) && (!st_reg.q[q].out_valid || ren[q]);
          st_next.q[q].out_valid = shift || (st_reg.q[q].out_valid && !ren[q]);
        end else begin
          shift = ren[q] && st_reg.q[q].empty_n;
        end
        // a word leaving memory frees its slot at once
        st_next.q[q].rptr = st_reg.q[q].rptr + {10'h000, shift};
        rcnt = rcnt - {10'h000, shift};
        lvl = (rcnt <= {1'b0, st_reg.q[q].low_off}) ? LVL_AT :
              dist_level(rcnt - {1'b0, st_reg.q[q].low_off});
        st_next.q[q].almost_empty_n = (lvl != LVL_AT);
        st_next.q[q].empty_n = st_reg.bus.fall_through_mode ? st_next.q[q].out_valid :
                               (rcnt != 11'h000);
      end
    end
    // bus slave: one wait cycle, then the access completes
    if ((avs_req.read || avs_req.write) && st_reg.bus.wait_rq) begin
      st_next.bus.wait_rq = 1'b0;
      unique case (avs_req.address)
        `REG_CTRL: st_next.bus.rdata = {29'h0, st_reg.bus.depth_sel,
                                       st_reg.bus.fall_through_mode};
        `REG_OFF1: st_next.bus.rdata = {6'h00, st_reg.q[0].high_off,
                                       6'h00, st_reg.q[0].low_off};
        `REG_OFF2: st_next.bus.rdata = {6'h00, st_reg.q[1].high_off,
                                       6'h00, st_reg.q[1].low_off};
        `REG_STATUS: st_next.bus.rdata = {
          19'h0, st_reg.q[1].out_valid, st_reg.q[1].full_n, st_reg.q[1].almost_full_n,
          st_reg.q[1].almost_empty_n, st_reg.q[1].empty_n,
          3'h0, st_reg.q[0].out_valid, st_reg.q[0].full_n, st_reg.q[0].almost_full_n,
          st_reg.q[0].almost_empty_n, st_reg.q[0].empty_n};
        default: st_next.bus.rdata = 32'h0000_0000;
      endcase
    end else begin
      st_next.bus.wait_rq = 1'b1;
    end
    // writes take effect on the edge the master sees waitrequest low
    if (avs_req.write && !st_reg.bus.wait_rq) begin
      unique case (avs_req.address)
        `REG_CTRL: begin
          wd = merge({29'h0, st_reg.bus.depth_sel, st_reg.bus.fall_through_mode},
                     avs_req.writedata, avs_req.byteenable);
          st_next.bus.fall_through_mode = wd[`CTRL_FALL_THROUGH_BIT];
          st_next.bus.depth_sel = wd[`CTRL_DEPTH_LSB +: 2];
        end
        `REG_OFF1, `REG_OFF2: begin
          for (int q = 0; q < 2; q++) begin
            if (avs_req.address == ((q == 0) ? `REG_OFF1 : `REG_OFF2)) begin
              wd = merge({6'h00, st_reg.q[q].high_off, 6'h00, st_reg.q[q].low_off},
                         avs_req.writedata, avs_req.byteenable);
              st_next.q[q].low_off = wd[9:0];
              st_next.q[q].high_off = wd[`OFF_HIGH_LSB +: 10];
            end
          end
        end
        `REG_SERIAL: begin
          // serial load shifts one bit through all four offsets
          if (avs_req.byteenable[0]) begin
            chain = {st_reg.q[0].low_off, st_reg.q[0].high_off,
                     st_reg.q[1].low_off, st_reg.q[1].high_off};
            chain = {chain[38:0], avs_req.writedata[0]};
            {st_next.q[0].low_off, st_next.q[0].high_off,
             st_next.q[1].low_off, st_next.q[1].high_off} = chain;
          end
        end
        default: wd = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flops
  assign tx_port_empty_or_ready = st_reg.q[0].empty_n;
  assign tx_port_almost_empty = st_reg.q[0].almost_empty_n;
  assign wide_port_almost_full = st_reg.q[0].almost_full_n;
  assign wide_port_full_or_input_ready = st_reg.q[0].full_n;
  assign wide_port_empty_or_ready = st_reg.q[1].empty_n;
  assign wide_port_almost_empty = st_reg.q[1].almost_empty_n;
  assign rx_port_almost_full = st_reg.q[1].almost_full_n;
  assign rx_port_full_or_input_ready = st_reg.q[1].full_n;
  assign avs_readdata = st_reg.bus.rdata;
  assign avs_waitrequest = st_reg.bus.wait_rq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_full_blocks;
    wtick[0] && wen[0] && !st_reg.q[0].full_n |=> $stable(st_reg.q[0].wptr);
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("write taken while full");

  property p_wptr_step;
    wacc[1] |=> st_reg.q[1].wptr == $past(st_reg.q[1].wptr) + 11'h001;
  endproperty
  a_wptr_step: assert property (p_wptr_step) else $error("write pointer step wrong");

  property p_empty_blocks;
    rtick[0] && ren[0] && !st_reg.bus.fall_through_mode && !st_reg.q[0].empty_n
      |=> $stable(st_reg.q[0].rptr);
  endproperty
  a_empty_blocks: assert property (p_empty_blocks) else $error("read taken while empty");

  property p_ae_level;
    rtick[1] |=> st_reg.q[1].almost_empty_n == (rcnt_obs[1] > {1'b0, st_reg.q[1].low_off});
  endproperty
  a_ae_level: assert property (p_ae_level) else $error("almost-empty level wrong");

  property p_af_level;
    wtick[0] |=> st_reg.q[0].almost_full_n ==
      (wcnt_obs[0] < cap_w - {1'b0, st_reg.q[0].high_off});
  endproperty
  a_af_level: assert property (p_af_level) else $error("almost-full level wrong");

  property p_empty_match;
    rtick[0] && !st_reg.bus.fall_through_mode
      |=> st_reg.q[0].empty_n == (rcnt_obs[0] != 11'h000);
  endproperty
  a_empty_match: assert property (p_empty_match) else $error("empty flag mismatch");

  property p_fall_through_shift;
    rtick[1] && st_reg.bus.fall_through_mode && !st_reg.q[1].out_valid &&
      (gray2bin(st_reg.q[1].wview_a) != st_reg.q[1].rptr) |=> st_reg.q[1].out_valid;
  endproperty
  a_fall_through_shift: assert property (p_fall_through_shift)
    else $error("first word not shifted");

  property p_out_excluded;
    $rose(st_reg.q[1].out_valid) |-> st_reg.q[1].rptr == $past(st_reg.q[1].rptr) + 11'h001;
  endproperty
  a_out_excluded: assert property (p_out_excluded) else $error("output word still counted");

  property p_flag_on_edge;
    $changed(st_reg.q[0].full_n) |-> $past(wtick[0]);
  endproperty
  a_flag_on_edge: assert property (p_flag_on_edge) else $error("full flag moved off edge");

  // mirrors on the other queue and the remaining flags
  property p_full_blocks_rx;
    wtick[1] && wen[1] && !st_reg.q[1].full_n |=> $stable(st_reg.q[1].wptr);
  endproperty
  a_full_blocks_rx: assert property (p_full_blocks_rx)
    else $error("rx write taken while full");

  property p_wptr_step_wide;
    wacc[0] |=> st_reg.q[0].wptr == $past(st_reg.q[0].wptr) + 11'h001;
  endproperty
  a_wptr_step_wide: assert property (p_wptr_step_wide)
    else $error("wide write pointer step wrong");

  property p_full_level;
    wtick[0] |=> st_reg.q[0].full_n == (wcnt_obs[0] != cap_w);
  endproperty
  a_full_level: assert property (p_full_level)
    else $error("wide full flag level wrong");

  property p_full_level_rx;
    wtick[1] |=> st_reg.q[1].full_n == (wcnt_obs[1] != cap_w);
  endproperty
  a_full_level_rx: assert property (p_full_level_rx)
    else $error("rx full flag level wrong");

  property p_ae_level_tx;
    rtick[0] |=> st_reg.q[0].almost_empty_n ==
      (rcnt_obs[0] > {1'b0, st_reg.q[0].low_off});
  endproperty
  a_ae_level_tx: assert property (p_ae_level_tx)
    else $error("tx almost-empty level wrong");

  property p_af_level_rx;
    wtick[1] |=> st_reg.q[1].almost_full_n ==
      (wcnt_obs[1] < cap_w - {1'b0, st_reg.q[1].high_off});
  endproperty
  a_af_level_rx: assert property (p_af_level_rx)
    else $error("rx almost-full level wrong");

  property p_rptr_step_tx;
    rtick[0] && ren[0] && !st_reg.bus.fall_through_mode && st_reg.q[0].empty_n
      |=> st_reg.q[0].rptr == $past(st_reg.q[0].rptr) + 11'h001;
  endproperty
  a_rptr_step_tx: assert property (p_rptr_step_tx)
    else $error("tx read did not free a slot");

  property p_hold_output;
    rtick[1] && st_reg.bus.fall_through_mode && st_reg.q[1].out_valid && !ren[1]
      |=> st_reg.q[1].out_valid && $stable(st_reg.q[1].rptr);
  endproperty
  a_hold_output: assert property (p_hold_output)
    else $error("output word moved without a read");

  property p_tx_flag_on_edge;
    $changed(st_reg.q[0].empty_n) |-> $past(rtick[0]);
  endproperty
  a_tx_flag_on_edge: assert property (p_tx_flag_on_edge)
    else $error("tx empty flag moved off edge");

  property p_rx_flag_on_edge;
    $changed(st_reg.q[1].full_n) |-> $past(wtick[1]);
  endproperty
  a_rx_flag_on_edge: assert property (p_rx_flag_on_edge)
    else $error("rx full flag moved off edge");

  property p_wide_ae_on_edge;
    $changed(st_reg.q[1].almost_empty_n) |-> $past(rtick[1]);
  endproperty
  a_wide_ae_on_edge: assert property (p_wide_ae_on_edge)
    else $error("wide almost-empty moved off edge");

endmodule : dual_fifo_status_flags
`default_nettype wire

// File: logic/dual_fifo_consts.svh
`ifndef DUAL_FIFO_CONSTS_SVH
`define DUAL_FIFO_CONSTS_SVH
// register byte addresses
`define REG_CTRL 8'h00
`define REG_OFF1 8'h04
`define REG_OFF2 8'h08
`define REG_SERIAL 8'h0C
`define REG_STATUS 8'h10
// field positions
`define CTRL_FALL_THROUGH_BIT 0
`define CTRL_DEPTH_LSB 1
`define OFF_HIGH_LSB 16
// reset values
`define OFF_PRESET 10'h008
`define DEPTH_PRESET 2'h2
// timing
`define CLK_PERIOD_NS 100
`define SKEW_NS 100
`define SKEW_CYC ((`SKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: logic/dual_fifo_pkg.sv
`default_nettype none
package dual_fifo_pkg;
  // fill comparator outcome: at threshold, one or two away, or clear of it
  typedef enum logic [1:0] {
    LVL_CLEAR = 2'b00,
    LVL_NEAR2 = 2'b01,
    LVL_NEAR1 = 2'b10,
    LVL_AT = 2'b11
  } cmp_level_t;

  typedef struct packed {
    logic [10:0] wptr;
    logic [10:0] rptr;
    logic [10:0] wview_a;
    logic [10:0] wview_b;
    logic [10:0] rview_a;
    logic [10:0] rview_b;
    logic empty_n;
    logic almost_empty_n;
    logic almost_full_n;
    logic full_n;
    logic out_valid;
    logic [9:0] low_off;
    logic [9:0] high_off;
  } queue_state_t;

  typedef struct packed {
    logic [6:0] s0;
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] lvl;
  } pin_sync_t;

  typedef struct packed {
    logic fall_through_mode;
    logic [1:0] depth_sel;
    logic wait_rq;
    logic [31:0] rdata;
  } bus_state_t;

  typedef struct packed {
    queue_state_t [1:0] q;
    pin_sync_t pins;
    bus_state_t bus;
  } block_state_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avalon_req_t;
endpackage : dual_fifo_pkg
`default_nettype wire

// File: testbench/port_host.sv
`default_nettype none
module port_host (
  // system
  input wire logic core_clk,
  // port pins
  output logic pclk,
  output logic [1:0] en
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle port: clock stands low, nothing enabled
  initial begin
    pclk = 1'b0;
    en = 2'h0;
  end
  // one port clock cycle per word; enables settle early and hold past the rise
  task automatic run(input int n, input logic [1:0] e);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      en <= e;
      repeat (4) @(posedge core_clk);
      pclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      pclk <= 1'b0;
    end
    @(posedge core_clk);
    en <= 2'h0;
  endtask : run
endmodule : port_host
`default_nettype wire

// File: testbench/dual_fifo_status_flags_tb_top.sv
`include "dual_fifo_consts.svh"
`default_nettype none
module dual_fifo_status_flags_tb_top
  import dual_fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk;
  logic arst_n;
  logic wide_clk;
  logic tx_clk;
  logic rx_clk;
  logic [1:0] wide_en;
  logic [1:0] tx_en;
  logic [1:0] rx_en;
  wire [7:0] flags;
  avalon_req_t avs_req;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic snap_req;
  logic [31:0] rd_q[$];
  logic [7:0] flag_q[$];
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int x_off;
  // flag order: empty wide/tx, almost-empty wide/tx, almost-full wide/rx, full wide/rx
  dual_fifo_status_flags uut (
    .core_clk(core_clk), .arst_n(arst_n),
    .wide_port_clock(wide_clk), .tx_port_clock(tx_clk), .rx_port_clock(rx_clk),
    .wide_wr_en(wide_en[0]), .wide_rd_en(wide_en[1]),
    .tx_rd_en(tx_en[0]), .rx_wr_en(rx_en[0]),
    .wide_port_empty_or_ready(flags[7]), .tx_port_empty_or_ready(flags[6]),
    .wide_port_almost_empty(flags[5]), .tx_port_almost_empty(flags[4]),
    .wide_port_almost_full(flags[3]), .rx_port_almost_full(flags[2]),
    .wide_port_full_or_input_ready(flags[1]), .rx_port_full_or_input_ready(flags[0]),
    .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );
  port_host wide_host (.core_clk(core_clk), .pclk(wide_clk), .en(wide_en));
  port_host tx_host (.core_clk(core_clk), .pclk(tx_clk), .en(tx_en));
  port_host rx_host (.core_clk(core_clk), .pclk(rx_clk), .en(rx_en));
  // 10 MHz system clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // avalon master: hold the request until waitrequest is sampled low
  task automatic bus_go(input logic [7:0] a, input logic rd, input logic [31:0] d);
    @(posedge core_clk);
    avs_req <= '{address: a, read: rd, write: !rd, byteenable: 4'hF, writedata: d};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask : bus_go
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus_go(a, 1'b1, 32'h0);
  endtask : bus_rd
  // note the expected flags, then strobe the watcher
  task automatic snap(input logic [7:0] e);
    flag_q.push_back(e);
    @(posedge core_clk);
    snap_req <= 1'b1;
    @(posedge core_clk);
    snap_req <= 1'b0;
  endtask : snap
  // watcher: compares each result against the oldest note
  always @(posedge core_clk) begin
    if (avs_req.read && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
      check("readdata", avs_readdata, rd_q.pop_front());
    end
    if (snap_req && flag_q.size() > 0) begin
      check("flags", {24'h0, flags}, {24'h0, flag_q.pop_front()});
    end
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    void'($urandom(95994));
    arst_n = 1'b0;
    avs_req = '0;
    snap_req = 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    snap(8'b0000_1111);
    bus_rd(`REG_CTRL, 32'h0000_0004);
    bus_rd(`REG_OFF1, 32'h0008_0008);
    bus_go(8'h14, 1'b0, 32'hFFFF_FFFF);
    bus_rd(8'h14, 32'h0);
    x_off = 1 + ($urandom % 6);
    bus_go(`REG_CTRL, 1'b0, 32'h0);
    bus_go(`REG_OFF1, 1'b0, (32'h4 << 16) | x_off);
    bus_rd(`REG_OFF1, (32'h4 << 16) | x_off);
    // first queue, standard mode, 256 words; a read on the empty queue is ignored
    tx_host.run(1, 2'b01);
    snap(8'b0000_1111);
    wide_host.run(x_off, 2'b01);
    tx_host.run(2, 2'b00);
    snap(8'b0100_1111);
    wide_host.run(1, 2'b01);
    tx_host.run(1, 2'b00);
    snap(8'b0100_1111);
    tx_host.run(1, 2'b00);
    snap(8'b0101_1111);
    wide_host.run(251 - x_off - 1, 2'b01);
    snap(8'b0101_1111);
    wide_host.run(1, 2'b01);
    snap(8'b0101_0111);
    wide_host.run(3, 2'b01);
    snap(8'b0101_0111);
    wide_host.run(1, 2'b01);
    snap(8'b0101_0101);
    wide_host.run(1, 2'b01);
    snap(8'b0101_0101);
    // let the tx side see the writes before it reads
    tx_host.run(2, 2'b00);
    tx_host.run(1, 2'b01);
    wide_host.run(1, 2'b00);
    snap(8'b0101_0101);
    wide_host.run(1, 2'b00);
    snap(8'b0101_0111);
    // second queue, fall-through mode
    bus_go(`REG_CTRL, 1'b0, 32'h1);
    bus_rd(`REG_CTRL, 32'h1);
    rx_host.run(1, 2'b01);
    wide_host.run(1, 2'b00);
    snap(8'b0101_0111);
    wide_host.run(1, 2'b00);
    snap(8'b1101_0111);
    rx_host.run(9, 2'b01);
    wide_host.run(1, 2'b00);
    snap(8'b1101_0111);
    wide_host.run(1, 2'b00);
    snap(8'b1111_0111);
    rx_host.run(246, 2'b01);
    snap(8'b1111_0011);
    rx_host.run(1, 2'b01);
    snap(8'b1111_0010);
    // wide side catches up, then reads one word through the output register
    wide_host.run(2, 2'b00);
    wide_host.run(1, 2'b10);
    snap(8'b1111_0010);
    // rx writes refused until the freed slot is seen two rx edges later
    rx_host.run(2, 2'b01);
    snap(8'b1111_0011);
    stop_test();
  end
endmodule : dual_fifo_status_flags_tb_top
`default_nettype wire
